/* File: common/event_line_consts.svh */
`ifndef EVENT_LINE_CONSTS_SVH
`define EVENT_LINE_CONSTS_SVH
// Register byte addresses on APB
`define ADDR_EVENT_QUEUE 8'h00
`define ADDR_LINE_BANK 8'h04
`define ADDR_EXT_CONTROL 8'h08
`define ADDR_MODEM_STATE 8'h0C
`define ADDR_LINE_COND 8'h10
`define ADDR_STATUS_IN 8'h14
// Event flag positions
`define EV_RX_HIGH 0
`define EV_TX_LOW 1
`define EV_LINK 2
`define EV_MODEM 3
`define EV_TC 4
`define EV_TX_IDLE 5
// Queue control fields
`define QC_ENABLE 0
`define QC_RX_CLR 1
`define QC_TX_CLR 2
// Line format fields
`define LF_STOP 2
`define LF_PAR_ON 3
`define LF_EVEN 4
`define LF_STICK 5
`define LF_BREAK 6
`define LF_BANK_SEL 7
// Extended control fields
`define XC_EXT_SEL 0
`define XC_IR_MS_SEL 1
`define XC_MODE_LSB 2
// Reset values and the legacy no-event code
`define LINE_FORMAT_RESET 8'h00
`define BANK_PICK_RESET 8'h00
`define LEGACY_NONE 8'h01
`endif

/* File: common/event_line_pkg.sv */
package event_line_pkg;
  typedef enum logic [1:0] {
    MODE_UART,
    MODE_SHIFT_IR,
    MODE_SIR,
    MODE_CONSUMER_IR
  } op_mode_t;
endpackage

/* File: logic/event_line_ctrl.sv */
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "event_line_consts.svh"
module event_line_ctrl
  import event_line_pkg::*;
#(
  parameter int FIFO_LEVEL_W = 5
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_char_held,
  input wire logic tx_holding_empty,
  input wire logic [FIFO_LEVEL_W-1:0] rx_level,
  input wire logic [FIFO_LEVEL_W-1:0] tx_level,
  input wire logic rx_timeout,
  input wire logic rx_error_at_bottom,
  input wire logic rx_overrun,
  input wire logic tx_underrun,
  input wire logic [3:0] modem_change_bits,
  input wire logic [7:0] line_condition_in,
  input wire logic terminal_count,
  input wire logic transmitter_idle_status,
  input wire logic ir_internal_mod,
  input wire logic tx_serial_data,
  input wire logic tx_ir_data,
  input wire logic ir_pulse_tick,
  output logic serial_out_pin,
  output logic infrared_out_pin,
  output logic fifo_enable,
  output logic receiver_clear_strobe,
  output logic transmitter_clear_strobe,
  output logic rx_high_level_flag,
  output logic tx_low_level_flag,
  output logic [3:0] data_bits,
  output logic [1:0] stop_halves,
  output logic parity_on,
  output logic parity_fixed,
  output logic parity_fixed_value,
  output logic parity_even
);

  logic [7:0] event_flags_reg;
  logic [7:0] line_format_reg;
  logic [7:0] bank_pick_reg;
  logic [1:0] tx_level_select;
  logic [1:0] rx_level_select;
  logic [3:0] extended_control_one;
  logic link_error_flag;
  logic modem_change_flag;
  logic terminal_count_flag;
  logic fifo_on_reg;
  logic infrared_modem_status_select;
  logic extended_select;
  op_mode_t mode;
  logic acc;
  logic wr;
  logic rd;
  logic rd_event;
  logic rd_modem;
  logic rd_cond;
  logic fifo_eff;
  logic rx_event;
  logic tx_event;
  logic ir_pulse_reg;
  logic [7:0] legacy_code;
  logic [7:0] read_next;

  function automatic logic [FIFO_LEVEL_W-1:0] tx_threshold(
    input logic [1:0] code
  );
    case (code)
      2'h0: tx_threshold = FIFO_LEVEL_W'(1);
      2'h1: tx_threshold = FIFO_LEVEL_W'(3);
      2'h2: tx_threshold = FIFO_LEVEL_W'(9);
      default: tx_threshold = FIFO_LEVEL_W'(13);
    endcase
  endfunction

  function automatic logic [FIFO_LEVEL_W-1:0] rx_threshold(
    input logic [1:0] code
  );
    case (code)
      2'h0: rx_threshold = FIFO_LEVEL_W'(1);
      2'h1: rx_threshold = FIFO_LEVEL_W'(4);
      2'h2: rx_threshold = FIFO_LEVEL_W'(8);
      default: rx_threshold = FIFO_LEVEL_W'(14);
    endcase
  endfunction

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign rd_event = rd && (paddr == `ADDR_EVENT_QUEUE);
  assign rd_modem = rd && (paddr == `ADDR_MODEM_STATE);
  assign rd_cond = rd && (paddr == `ADDR_LINE_COND);
  assign extended_select = extended_control_one[`XC_EXT_SEL];
  assign infrared_modem_status_select = extended_control_one[`XC_IR_MS_SEL];
  assign mode = op_mode_t'(extended_control_one[3:2]);
  assign fifo_eff = fifo_on_reg || (mode == MODE_CONSUMER_IR);

  // Level events follow their sources; no separate acknowledge needed
  always_comb begin
    if (fifo_eff) begin
      rx_event = (rx_level >= rx_threshold(rx_level_select)) ||
        rx_timeout;
      tx_event = tx_level < tx_threshold(tx_level_select);
    end else begin
      rx_event = rx_char_held;
      tx_event = tx_holding_empty;
    end
  end

  // APB: zero wait state, every access completes the cycle after setup
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > `ADDR_STATUS_IN;
    end
  end

  // Writes land only on the access cycle with pready high
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fifo_on_reg <= 1'b0;
      tx_level_select <= 2'h0;
      rx_level_select <= 2'h0;
      receiver_clear_strobe <= 1'b0;
      transmitter_clear_strobe <= 1'b0;
    end else begin
      receiver_clear_strobe <= 1'b0;
      transmitter_clear_strobe <= 1'b0;
      if (wr && pready && paddr == `ADDR_EVENT_QUEUE) begin
        fifo_on_reg <= pwdata[`QC_ENABLE];
        receiver_clear_strobe <= pwdata[`QC_RX_CLR];
        transmitter_clear_strobe <= pwdata[`QC_TX_CLR];
        tx_level_select <= pwdata[5:4];
        rx_level_select <= pwdata[7:6];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      line_format_reg <= `LINE_FORMAT_RESET;
      bank_pick_reg <= `BANK_PICK_RESET;
      extended_control_one <= 4'h0;
    end else if (wr && pready) begin
      if (paddr == `ADDR_LINE_BANK) begin
        bank_pick_reg <= pwdata[7:0];
        if (!pwdata[`LF_BANK_SEL]) begin
          line_format_reg <= pwdata[7:0];
        end
      end else if (paddr == `ADDR_EXT_CONTROL) begin
        extended_control_one <= pwdata[3:0];
      end
    end
  end

  // Sticky events; a new event beats a clearing read in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      link_error_flag <= 1'b0;
      modem_change_flag <= 1'b0;
      terminal_count_flag <= 1'b0;
    end else begin
      if (mode == MODE_CONSUMER_IR && (rx_overrun || tx_underrun)) begin
        link_error_flag <= 1'b1;
      end else if (mode != MODE_CONSUMER_IR &&
                   (rx_error_at_bottom || rx_overrun)) begin
        link_error_flag <= 1'b1;
      end else if (rd_cond && pready) begin
        link_error_flag <= 1'b0;
      end
      if (|modem_change_bits) begin
        modem_change_flag <= 1'b1;
      end else if (rd_modem && pready) begin
        modem_change_flag <= 1'b0;
      end
      if (terminal_count) begin
        terminal_count_flag <= 1'b1;
      end else if (rd_event && pready) begin
        terminal_count_flag <= 1'b0;
      end
    end
  end

  always_comb begin
    event_flags_reg = 8'h00;
    event_flags_reg[`EV_RX_HIGH] = rx_event;
    event_flags_reg[`EV_TX_LOW] = tx_event;
    event_flags_reg[`EV_LINK] = link_error_flag;
    event_flags_reg[`EV_MODEM] = modem_change_flag &&
      (mode == MODE_UART || !infrared_modem_status_select);
    event_flags_reg[`EV_TC] = terminal_count_flag;
    event_flags_reg[`EV_TX_IDLE] = transmitter_idle_status &&
      (mode != MODE_SIR);
  end

  // Legacy priority encoding when extended select is low
  always_comb begin
    if (link_error_flag) begin
      legacy_code = 8'h06;
    end else if (rx_event) begin
      legacy_code = (fifo_eff && rx_timeout) ? 8'h0C : 8'h04;
    end else if (tx_event) begin
      legacy_code = 8'h02;
    end else if (modem_change_flag) begin
      legacy_code = 8'h00;
    end else begin
      legacy_code = `LEGACY_NONE;
    end
    if (fifo_eff) begin
      legacy_code = legacy_code | 8'hC0;
    end
  end

  always_comb begin
    if (paddr == `ADDR_EVENT_QUEUE) begin
      read_next = extended_select ? event_flags_reg : legacy_code;
    end else if (paddr == `ADDR_LINE_BANK) begin
      read_next = bank_pick_reg;
    end else if (paddr == `ADDR_EXT_CONTROL) begin
      read_next = {4'h0, extended_control_one};
    end else if (paddr == `ADDR_LINE_COND) begin
      read_next = line_condition_in;
    end else if (paddr == `ADDR_STATUS_IN) begin
      read_next = {1'b0, line_format_reg[6:0]};
    end else begin
      read_next = 8'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, read_next};
    end
  end

  // Format decode; consumer IR ignores line format bits
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      data_bits <= 4'h5;
      stop_halves <= 2'h2;
      parity_on <= 1'b0;
      parity_fixed <= 1'b0;
      parity_fixed_value <= 1'b0;
      parity_even <= 1'b0;
    end else if (mode != MODE_CONSUMER_IR) begin
      data_bits <= 4'h5 + {2'h0, line_format_reg[1:0]};
      if (!line_format_reg[`LF_STOP]) begin
        stop_halves <= 2'h2;
      end else begin
        stop_halves <= (line_format_reg[1:0] == 2'h0) ? 2'h3 : 2'h0;
      end
      parity_on <= line_format_reg[`LF_PAR_ON];
      parity_even <= line_format_reg[`LF_EVEN];
      parity_fixed <= line_format_reg[`LF_STICK];
      parity_fixed_value <= !line_format_reg[`LF_EVEN];
    end
  end

  // Break only overrides the front end, the shifter keeps timing
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      serial_out_pin <= 1'b1;
      infrared_out_pin <= 1'b0;
      ir_pulse_reg <= 1'b0;
    end else begin
      ir_pulse_reg <= ir_pulse_tick;
      if (line_format_reg[`LF_BREAK] && mode != MODE_CONSUMER_IR) begin
        serial_out_pin <= (mode == MODE_UART) ? 1'b0 :
          tx_serial_data;
        if (mode == MODE_SIR ||
            (mode == MODE_SHIFT_IR && ir_internal_mod)) begin
          infrared_out_pin <= ir_pulse_reg;
        end else if (mode == MODE_SHIFT_IR) begin
          infrared_out_pin <= 1'b1;
        end else begin
          infrared_out_pin <= tx_ir_data;
        end
      end else begin
        serial_out_pin <= tx_serial_data;
        infrared_out_pin <= tx_ir_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fifo_enable <= 1'b0;
      rx_high_level_flag <= 1'b0;
      tx_low_level_flag <= 1'b0;
    end else begin
      fifo_enable <= fifo_eff;
      rx_high_level_flag <= rx_event;
      tx_low_level_flag <= tx_event;
    end
  end

  AST_TC_CLEAR: assert property (
    @(posedge ref_clk) disable iff (reset)
    (rd_event && pready && !terminal_count) |=> !terminal_count_flag)
    else $error("terminal count flag not cleared by read");
  AST_TC_SET: assert property (
    @(posedge ref_clk) disable iff (reset)
    terminal_count |=> event_flags_reg[`EV_TC])
    else $error("terminal count flag not set");
  AST_MODEM_HOLD: assert property (
    @(posedge ref_clk) disable iff (reset)
    (modem_change_flag && !rd_modem) |=> modem_change_flag)
    else $error("modem flag lost without acknowledge");
  AST_TOP_ZERO: assert property (
    @(posedge ref_clk) disable iff (reset)
    (rd_event && pready && extended_select) |-> prdata[7:6] == 2'h0)
    else $error("reserved event bits nonzero");
  AST_IR_MODEM: assert property (
    @(posedge ref_clk) disable iff (reset)
    (mode != MODE_UART && infrared_modem_status_select)
      |-> !event_flags_reg[`EV_MODEM])
    else $error("modem event not forced low");
  AST_CLR_PULSE: assert property (
    @(posedge ref_clk) disable iff (reset)
    receiver_clear_strobe |=> !receiver_clear_strobe)
    else $error("receive clear not self clearing");
  AST_TX_CLR_PULSE: assert property (
    @(posedge ref_clk) disable iff (reset)
    transmitter_clear_strobe |=> !transmitter_clear_strobe)
    else $error("transmit clear not self clearing");
  AST_BANK_ONLY: assert property (
    @(posedge ref_clk) disable iff (reset)
    (wr && pready && paddr == `ADDR_LINE_BANK && pwdata[7])
      |=> $stable(line_format_reg))
    else $error("line format changed on bank write");
  AST_FMT_BOTH: assert property (
    @(posedge ref_clk) disable iff (reset)
    (wr && pready && paddr == `ADDR_LINE_BANK && !pwdata[`LF_BANK_SEL])
      |=> line_format_reg == $past(pwdata[7:0]))
    else $error("line format not written with bank");
  AST_LINK_SET: assert property (
    @(posedge ref_clk) disable iff (reset)
    (mode != MODE_CONSUMER_IR && (rx_overrun || rx_error_at_bottom))
      |=> link_error_flag)
    else $error("link event not raised");
  AST_BREAK_LOW: assert property (
    @(posedge ref_clk) disable iff (reset)
    (line_format_reg[`LF_BREAK] && mode == MODE_UART) [*2]
      |-> !serial_out_pin)
    else $error("break does not hold line low");
  AST_CIR_FIFO: assert property (
    @(posedge ref_clk) disable iff (reset)
    (mode == MODE_CONSUMER_IR) |=> fifo_enable)
    else $error("consumer IR fifo not enabled");

endmodule

/* File: verification/line_side_model.sv */
`timescale 1ns/1ps
module line_side_model #(
  parameter int FRAME_CYCLES = 12
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  output logic tx_serial_data,
  output logic tx_ir_data,
  output logic ir_pulse_tick,
  output logic transmitter_idle_status
);
  int busy_reg;
  logic [1:0] tick_reg;
  // Frame length is arbitrary; only idle versus busy matters here
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_reg <= 0;
    end else if (start) begin
      busy_reg <= FRAME_CYCLES;
    end else if (busy_reg > 0) begin
      busy_reg <= busy_reg - 1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick_reg <= 2'h0;
    end else begin
      tick_reg <= tick_reg + 2'h1;
    end
  end
  // Line rests at mark between frames, toggles within one
  assign tx_serial_data = (busy_reg == 0) ? 1'b1 : busy_reg[0];
  assign tx_ir_data = (busy_reg != 0) && busy_reg[0];
  assign ir_pulse_tick = (tick_reg == 2'h0);
  assign transmitter_idle_status = (busy_reg == 0);
endmodule

/* File: verification/uart_ir_event_fifo_line_ctrl_test.sv */
`timescale 1ns/1ps
module uart_ir_event_fifo_line_ctrl_test;
  logic ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, rerr, start = 1'b0;
  logic [7:0] paddr = 8'h00, line_condition_in = 8'h62;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic rx_char_held = 1'b0, tx_holding_empty = 1'b0;
  logic rx_overrun = 1'b0, tx_underrun = 1'b0, terminal_count = 1'b0;
  logic [4:0] rx_level = 5'h00, tx_level = 5'h00;
  logic [4:0] tl [4] = '{5'h01, 5'h03, 5'h09, 5'h0D};
  logic [4:0] rl [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  logic [3:0] modem_change_bits = 4'h0, data_bits;
  logic [1:0] stop_halves;
  logic tx_serial_data, tx_ir_data, ir_pulse_tick, idle;
  logic serial_out_pin, infrared_out_pin, fifo_enable, rx_clr, tx_clr;
  logic rx_high_level_flag, tx_low_level_flag, parity_on, parity_fixed;
  logic parity_fixed_value, parity_even;
  int err_total = 0, check_count = 0, rx_pulses = 0, tx_pulses = 0;
  int ir_highs = 0;
  logic rx_timeout = 1'b0, rx_error_at_bottom = 1'b0;
  logic ir_internal_mod = 1'b0;

  event_line_ctrl #(.FIFO_LEVEL_W(5)) uut (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_char_held(rx_char_held),
    .tx_holding_empty(tx_holding_empty), .rx_level(rx_level),
    .tx_level(tx_level), .rx_timeout(rx_timeout),
    .rx_error_at_bottom(rx_error_at_bottom),
    .rx_overrun(rx_overrun), .tx_underrun(tx_underrun),
    .modem_change_bits(modem_change_bits),
    .line_condition_in(line_condition_in),
    .terminal_count(terminal_count), .transmitter_idle_status(idle),
    .ir_internal_mod(ir_internal_mod), .tx_serial_data(tx_serial_data),
    .tx_ir_data(tx_ir_data), .ir_pulse_tick(ir_pulse_tick),
    .serial_out_pin(serial_out_pin), .infrared_out_pin(infrared_out_pin),
    .fifo_enable(fifo_enable), .receiver_clear_strobe(rx_clr),
    .transmitter_clear_strobe(tx_clr),
    .rx_high_level_flag(rx_high_level_flag),
    .tx_low_level_flag(tx_low_level_flag), .data_bits(data_bits),
    .stop_halves(stop_halves), .parity_on(parity_on),
    .parity_fixed(parity_fixed), .parity_fixed_value(parity_fixed_value),
    .parity_even(parity_even)
  );

  line_side_model far (
    .ref_clk(ref_clk), .reset(reset), .start(start),
    .tx_serial_data(tx_serial_data), .tx_ir_data(tx_ir_data),
    .ir_pulse_tick(ir_pulse_tick), .transmitter_idle_status(idle)
  );

  always #50 ref_clk = ~ref_clk;

  // Strobes are one cycle wide, so count them rather than sample once
  always @(posedge ref_clk) begin
    if (rx_clr === 1'b1) rx_pulses <= rx_pulses + 1;
    if (tx_clr === 1'b1) tx_pulses <= tx_pulses + 1;
  end

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr = pslverr;
    if (n >= 20) begin
      err_total++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, e);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (idle !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    if (n >= 100) begin
      err_total++;
      print_verdict();
    end
  endtask

  initial begin
    cyc(16);
    reset <= 1'b0;
    cyc(2);
    chk({data_bits, stop_halves, parity_on}, 7'h2C);
    rdc(8'h14, 32'hFF, 32'h00);
    rdc(8'h00, 32'hFF, 32'h01);
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, 32'(i));
      cyc(2);
      chk(data_bits, 32'(5 + i));
      wr(8'h04, 32'h08 | 32'(i << 4));
      cyc(2);
      chk({parity_on, parity_fixed}, {1'b1, i[1]});
      chk(i[1] ? parity_fixed_value : parity_even, i[1] ^ i[0]);
    end
    wr(8'h04, 32'h04);
    cyc(2);
    chk(stop_halves, 2'h3);
    wr(8'h04, 32'h07);
    cyc(2);
    chk(stop_halves, 2'h0);
    wr(8'h04, 32'h1B);
    wr(8'h04, 32'h85);
    cyc(2);
    rdc(8'h04, 32'hFF, 32'h85);
    rdc(8'h14, 32'hFF, 32'h1B);
    chk({data_bits, stop_halves}, 6'h22);
    start <= 1'b1;
    cyc(1);
    start <= 1'b0;
    wait_idle();
    wr(8'h04, 32'h43);
    cyc(3);
    chk(serial_out_pin, 1'b0);
    wait_idle();
    wr(8'h04, 32'h03);
    cyc(3);
    chk(serial_out_pin, 1'b1);
    wr(8'h08, 32'h01);
    rdc(8'h00, 32'hE0, 32'h20);
    rx_char_held <= 1'b1;
    tx_holding_empty <= 1'b1;
    cyc(2);
    rdc(8'h00, 32'h03, 32'h03);
    rx_char_held <= 1'b0;
    tx_holding_empty <= 1'b0;
    terminal_count <= 1'b1;
    rx_overrun <= 1'b1;
    modem_change_bits <= 4'h4;
    cyc(1);
    terminal_count <= 1'b0;
    rx_overrun <= 1'b0;
    modem_change_bits <= 4'h0;
    cyc(2);
    rdc(8'h00, 32'h1C, 32'h1C);
    rdc(8'h00, 32'h1C, 32'h0C);
    rdc(8'h10, 32'hFF, 32'h62);
    rdc(8'h0C, 32'hFF, 32'h00);
    rdc(8'h00, 32'h0C, 32'h00);
    for (int s = 0; s < 2; s++) begin
      wr(8'h08, 32'h05 | 32'(s << 1));
      modem_change_bits <= 4'h1;
      cyc(1);
      modem_change_bits <= 4'h0;
      cyc(2);
      rdc(8'h00, 32'h08, s ? 32'h0 : 32'h8);
      rdc(8'h0C, 32'hFF, 32'h00);
    end
    wr(8'h08, 32'h0D);
    tx_underrun <= 1'b1;
    cyc(1);
    tx_underrun <= 1'b0;
    cyc(2);
    rdc(8'h00, 32'h04, 32'h04);
    wr(8'h00, 32'h00);
    cyc(2);
    chk(fifo_enable, 1'b1);
    wr(8'h08, 32'h01);
    wr(8'h00, 32'h00);
    cyc(2);
    chk(fifo_enable, 1'b0);
    wr(8'h00, 32'h03);
    wr(8'h00, 32'h05);
    cyc(2);
    chk({rx_pulses[1:0], tx_pulses[1:0]}, 4'h5);
    chk({rx_clr, tx_clr, fifo_enable}, 3'h1);
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, 32'h01 | 32'(c << 4) | 32'(c << 6));
      tx_level <= tl[c] - 5'h01;
      rx_level <= rl[c] - 5'h01;
      cyc(3);
      chk({tx_low_level_flag, rx_high_level_flag}, 2'h2);
      tx_level <= tl[c];
      rx_level <= rl[c];
      cyc(3);
      chk({tx_low_level_flag, rx_high_level_flag}, 2'h1);
      rdc(8'h00, 32'h03, 32'h01);
    end
    rdc(8'h10, 32'hFF, 32'h62);
    rdc(8'h00, 32'h04, 32'h00);
    rx_error_at_bottom <= 1'b1;
    cyc(1);
    rx_error_at_bottom <= 1'b0;
    cyc(2);
    rdc(8'h00, 32'h04, 32'h04);
    rdc(8'h10, 32'hFF, 32'h62);
    rx_level <= 5'h00;
    rx_timeout <= 1'b1;
    cyc(2);
    rdc(8'h00, 32'h01, 32'h01);
    wr(8'h08, 32'h00);
    rdc(8'h00, 32'hFF, 32'hCC);
    rx_timeout <= 1'b0;
    wait_idle();
    wr(8'h04, 32'h43);
    // Partner ticks once every four cycles, so eight samples see two
    for (int m = 0; m < 2; m++) begin
      wr(8'h08, m ? 32'h04 : 32'h08);
      ir_internal_mod <= m[0];
      cyc(3);
      ir_highs = 0;
      repeat (8) begin
        cyc(1);
        if (infrared_out_pin === 1'b1) ir_highs++;
      end
      chk(ir_highs, 2);
    end
    ir_internal_mod <= 1'b0;
    cyc(3);
    chk(infrared_out_pin, 1'b1);
    wait_idle();
    wr(8'h04, 32'h03);
    rdc(8'h20, 32'hFFFFFFFF, 32'h0);
    chk(rerr, 1'b1);
    print_verdict();
  end
endmodule
